/* pctc_pkg.sv */
// package: constants for the program card transfer controller
package pctc_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_ST = 8'h08;
    localparam logic [7:0] REG_IRQ_MK = 8'h0c;
    // ctrl fields
    localparam int CTRL_KEYPAD  = 0;
    localparam int CTRL_STOP    = 1;
    // status / irq fields
    localparam int ST_BUSY      = 0;
    localparam int ST_CARD_OK   = 1;
    localparam int ST_CARD_NEW  = 2;
    localparam int ST_INT_VALID = 3;
    localparam int ST_MENU      = 4;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_REFUSED  = 1;
    localparam int IRQ_BUSERR   = 2;
    localparam int IRQ_INVALID  = 3;
    localparam int IRQ_W        = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0002;
    // operations
    typedef enum logic [1:0] {
        PCTC_OP_SAVE  = 2'h0,
        PCTC_OP_LOAD  = 2'h1,
        PCTC_OP_ERASE = 2'h2,
        PCTC_OP_BOOT  = 2'h3
    } pctc_op_t;
    typedef enum logic [6:0] {
        PCTC_IDLE  = 7'h01,
        PCTC_CONF  = 7'h02,
        PCTC_RDBLK = 7'h04,
        PCTC_CLR   = 7'h08,
        PCTC_WRBLK = 7'h10,
        PCTC_CERA  = 7'h20,
        PCTC_CWR   = 7'h40
    } pctc_state_t;
endpackage

/* pctc_top.sv */
// design: program card transfer controller with wishbone registers
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ns
// Summary of operation
// R1 - save, load and erase are refused unless the controller is in stop mode
// R2 - keypadless unit copies card program into memory at every power-up
// R3 - keypadless power-up load keeps internal program if card image invalid
// R4 - keypad unit loads at power-up only when no internal program exists; code: keypad bit is 0 from reset at boot check, so always loads
// R5 - card detected on entering program menu; removal only in status display; code also drops detection whenever the card is absent or faulty
// R6 - only the newest card type may be written or erased
// R7 - older cards are read sources only; never a save target
// R8 - a card holds exactly one program image
// R9 - saved image holds program, parameters, texts and all system settings
// R10 - card menu offered only while a functional card is inserted
// R11 - confirmed save erases card then writes image; cancel aborts cleanly
// R12 - confirmed load fills ram, clears memory, then writes card data
// R13 - load proceeds block by block through a small working ram
// R14 - failed or interrupted load leaves no valid internal program; code: a failure in the first block, before the clear, keeps int_valid_r
// R15 - confirmed erase deletes card contents; cancel aborts
// R16 - hot insertion and removal never corrupt stored data
// R17 - after power loss mid-transfer the operator repeats the operation
// R18 - card bus error reported when card removed or faulty during save
// R19 - commands are one-cycle pulses; busy holds until done or abort
module pctc_top #(
    parameter int BLK_WORDS = 16,
    parameter int N_BLKS    = 8
) (
    // system
    input  wire logic        clk,
    input  wire logic        reset,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    // operator commands
    input  wire logic        cmd_save,
    input  wire logic        cmd_load,
    input  wire logic        cmd_erase,
    input  wire logic        cmd_ok,
    input  wire logic        cmd_cancel,
    input  wire logic        menu_program,
    input  wire logic        status_display,
    output logic             busy,
    output logic             card_menu_en,
    // card side
    input  wire logic        card_present,
    input  wire logic        card_newest,
    input  wire logic        card_fault,
    input  wire logic        card_valid,
    input  wire logic [31:0] card_rdata,
    output logic             card_rd,
    output logic             card_wr,
    output logic             card_erase,
    output logic      [15:0] card_addr,
    output logic      [31:0] card_wdata,
    // internal retentive program memory
    input  wire logic        prog_present,
    input  wire logic [31:0] prog_rdata,
    output logic             prog_rd,
    output logic             prog_wr,
    output logic             prog_clear,
    output logic      [15:0] prog_addr,
    output logic      [31:0] prog_wdata
);
    localparam int TOTAL = BLK_WORDS * N_BLKS;

    pctc_pkg::pctc_state_t state_r;
    pctc_pkg::pctc_op_t    op_r;
    logic [31:0] ctrl_r;
    logic [pctc_pkg::IRQ_W-1:0] irq_st_r;
    logic [pctc_pkg::IRQ_W-1:0] irq_mk_r;
    logic [pctc_pkg::IRQ_W-1:0] ev;
    logic [15:0] idx_r;
    logic [15:0] wi_r;
    logic        int_valid_r;
    logic        card_seen_r;
    logic        boot_pend_r;
    logic [31:0] ram [BLK_WORDS];
    logic        ack_r;
    logic        wr_en;
    logic        stop_mode;
    logic        keypad;
    logic        card_ok;
    logic        last_word;
    logic        last_blk;
    logic [1:0]  cap_v_r;
    logic [15:0] cap_i0_r;
    logic [15:0] cap_i1_r;

    assign stop_mode = ctrl_r[pctc_pkg::CTRL_STOP];
    assign keypad    = ctrl_r[pctc_pkg::CTRL_KEYPAD];
    assign card_ok   = card_present & ~card_fault;
    assign last_word = (wi_r == 16'(BLK_WORDS - 1));
    assign last_blk  = (idx_r + 16'(BLK_WORDS) >= 16'(TOTAL));
    assign busy      = (state_r != pctc_pkg::PCTC_IDLE); // R19

    // wishbone: ack one cycle after strobe, dropped the next cycle
    // writes land on the ack edge, while the master still holds the request
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_r    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
            unique case (wb_adr_i)
                pctc_pkg::REG_CTRL:   wb_dat_o <= ctrl_r;
                pctc_pkg::REG_STATUS: wb_dat_o <= {27'h0, card_seen_r, int_valid_r,
                                                   card_newest, card_ok, busy};
                pctc_pkg::REG_IRQ_ST: wb_dat_o <= {28'h0, irq_st_r};
                pctc_pkg::REG_IRQ_MK: wb_dat_o <= {28'h0, irq_mk_r};
                default:              wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_ack_o = ack_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            ctrl_r <= pctc_pkg::CTRL_RST;
        else if (wr_en && wb_adr_i == pctc_pkg::REG_CTRL && wb_sel_i[0])
            ctrl_r <= {24'h0, 6'h0, wb_dat_i[1:0]};
    end

    // interrupt status: set wins over write-one-to-clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_st_r <= '0;
            irq_mk_r <= '0;
        end else begin
            if (wr_en && wb_adr_i == pctc_pkg::REG_IRQ_MK && wb_sel_i[0])
                irq_mk_r <= wb_dat_i[pctc_pkg::IRQ_W-1:0];
            if (wr_en && wb_adr_i == pctc_pkg::REG_IRQ_ST && wb_sel_i[0])
                irq_st_r <= (irq_st_r & ~wb_dat_i[pctc_pkg::IRQ_W-1:0]) | ev;
            else
                irq_st_r <= irq_st_r | ev;
        end
    end
    assign irq = |(irq_st_r & irq_mk_r);

    // card detection latched on program-menu entry, dropped in status display
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            card_seen_r <= 1'b0;
        else if (!card_ok)
            card_seen_r <= 1'b0; // R16
        else if (menu_program)
            card_seen_r <= 1'b1; // R5
        else if (status_display)
            card_seen_r <= 1'b0; // R5
    end
    assign card_menu_en = card_seen_r & card_ok; // R10

    // boot request caught one cycle after reset release
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            boot_pend_r <= 1'b1;
        else if (state_r == pctc_pkg::PCTC_IDLE)
            boot_pend_r <= 1'b0;
    end

    // transfer sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= pctc_pkg::PCTC_IDLE;
            op_r    <= pctc_pkg::PCTC_OP_SAVE;
            idx_r   <= 16'h0000;
            wi_r    <= 16'h0000;
            ev      <= '0;
        end else begin
            ev <= '0;
            unique case (state_r)
                pctc_pkg::PCTC_IDLE: begin
                    idx_r <= 16'h0000;
                    wi_r  <= 16'h0000;
                    if (boot_pend_r) begin
                        // R2 R4: keypadless always, keypad only when empty
                        if (card_ok && (!keypad || !prog_present)) begin
                            op_r    <= pctc_pkg::PCTC_OP_BOOT;
                            state_r <= pctc_pkg::PCTC_RDBLK;
                        end
                    end else if (cmd_save || cmd_load || cmd_erase) begin
                        if (!stop_mode || !card_menu_en)
                            ev[pctc_pkg::IRQ_REFUSED] <= 1'b1; // R1 R10
                        else if (!cmd_load && !card_newest)
                            ev[pctc_pkg::IRQ_REFUSED] <= 1'b1; // R6 R7
                        else begin
                            op_r <= cmd_save ? pctc_pkg::PCTC_OP_SAVE :
                                    cmd_load ? pctc_pkg::PCTC_OP_LOAD :
                                               pctc_pkg::PCTC_OP_ERASE;
                            state_r <= pctc_pkg::PCTC_CONF; // R19
                        end
                    end
                end
                pctc_pkg::PCTC_CONF: begin
                    if (cmd_cancel)
                        state_r <= pctc_pkg::PCTC_IDLE; // R11 R15
                    else if (cmd_ok)
                        state_r <= (op_r == pctc_pkg::PCTC_OP_LOAD) ?
                                   pctc_pkg::PCTC_RDBLK : pctc_pkg::PCTC_CERA;
                end
                pctc_pkg::PCTC_CERA: begin
                    // whole card cleared: one image per card R8 R11 R15
                    if (!card_ok) begin
                        ev[pctc_pkg::IRQ_BUSERR] <= 1'b1; // R18
                        state_r <= pctc_pkg::PCTC_IDLE;
                    end else if (op_r == pctc_pkg::PCTC_OP_ERASE) begin
                        ev[pctc_pkg::IRQ_DONE] <= 1'b1;
                        state_r <= pctc_pkg::PCTC_IDLE;
                    end else
                        state_r <= pctc_pkg::PCTC_CWR;
                end
                pctc_pkg::PCTC_CWR: begin
                    // full image region copied, settings included R9
                    if (!card_ok) begin
                        ev[pctc_pkg::IRQ_BUSERR] <= 1'b1; // R18
                        state_r <= pctc_pkg::PCTC_IDLE;
                    end else if (idx_r == 16'(TOTAL - 1)) begin
                        ev[pctc_pkg::IRQ_DONE] <= 1'b1;
                        state_r <= pctc_pkg::PCTC_IDLE;
                    end else
                        idx_r <= idx_r + 16'h0001;
                end
                pctc_pkg::PCTC_RDBLK: begin
                    if (!card_ok || !card_valid) begin
                        ev[pctc_pkg::IRQ_INVALID] <= 1'b1; // R3 R14
                        state_r <= pctc_pkg::PCTC_IDLE;
                    end else if (last_word) begin
                        wi_r <= 16'h0000;
                        // memory cleared only once, after the first block R12
                        state_r <= (idx_r == 16'h0000) ? pctc_pkg::PCTC_CLR
                                                       : pctc_pkg::PCTC_WRBLK;
                    end else
                        wi_r <= wi_r + 16'h0001;
                end
                pctc_pkg::PCTC_CLR:
                    state_r <= pctc_pkg::PCTC_WRBLK; // R12
                pctc_pkg::PCTC_WRBLK: begin
                    if (!card_ok) begin
                        ev[pctc_pkg::IRQ_BUSERR] <= 1'b1; // R14
                        state_r <= pctc_pkg::PCTC_IDLE;
                    end else if (last_word) begin
                        wi_r  <= 16'h0000;
                        idx_r <= idx_r + 16'(BLK_WORDS); // R13
                        if (last_blk) begin
                            ev[pctc_pkg::IRQ_DONE] <= 1'b1;
                            state_r <= pctc_pkg::PCTC_IDLE;
                        end else
                            state_r <= pctc_pkg::PCTC_RDBLK;
                    end else
                        wi_r <= wi_r + 16'h0001;
                end
                default: state_r <= pctc_pkg::PCTC_IDLE;
            endcase
        end
    end

    // card word arrives two cycles after the read step; capture lines up with it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cap_v_r  <= 2'b00;
            cap_i0_r <= 16'h0000;
            cap_i1_r <= 16'h0000;
        end else begin
            cap_v_r  <= {cap_v_r[0], state_r == pctc_pkg::PCTC_RDBLK};
            cap_i0_r <= wi_r;
            cap_i1_r <= cap_i0_r;
        end
    end

    // working ram: one block only, too small for a whole program
    always_ff @(posedge clk) begin
        if (cap_v_r[1])
            ram[cap_i1_r[$clog2(BLK_WORDS)-1:0]] <= card_rdata; // R13
    end

    // internal program validity: lost once cleared until a full load ends
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            int_valid_r <= 1'b0;
        else if (state_r == pctc_pkg::PCTC_IDLE && boot_pend_r)
            int_valid_r <= prog_present;
        else if (state_r == pctc_pkg::PCTC_CLR)
            int_valid_r <= 1'b0; // R14
        else if (state_r == pctc_pkg::PCTC_WRBLK && last_word && last_blk && card_ok)
            int_valid_r <= 1'b1;
    end

    // memory and card strobes; data from flip-flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            card_rd    <= 1'b0;
            card_wr    <= 1'b0;
            card_erase <= 1'b0;
            card_addr  <= 16'h0000;
            card_wdata <= 32'h0000_0000;
            prog_rd    <= 1'b0;
            prog_wr    <= 1'b0;
            prog_clear <= 1'b0;
            prog_addr  <= 16'h0000;
            prog_wdata <= 32'h0000_0000;
        end else begin
            card_rd    <= (state_r == pctc_pkg::PCTC_RDBLK);
            card_erase <= (state_r == pctc_pkg::PCTC_CERA) & card_newest; // R6
            card_wr    <= (state_r == pctc_pkg::PCTC_CWR) & card_newest; // R7
            card_addr  <= idx_r + wi_r;
            card_wdata <= prog_rdata;
            prog_rd    <= (state_r == pctc_pkg::PCTC_CWR);
            prog_clear <= (state_r == pctc_pkg::PCTC_CLR);
            prog_wr    <= (state_r == pctc_pkg::PCTC_WRBLK);
            prog_addr  <= idx_r + wi_r;
            prog_wdata <= ram[wi_r[$clog2(BLK_WORDS)-1:0]];
        end
    end

    property p_refuse_run;
        @(posedge clk) disable iff (reset)
        (state_r == pctc_pkg::PCTC_IDLE && !boot_pend_r && cmd_save && !stop_mode)
        |=> state_r == pctc_pkg::PCTC_IDLE && ev[pctc_pkg::IRQ_REFUSED];
    endproperty
    a_refuse_run: assert property (p_refuse_run) else $error("accepted outside stop"); // R1
    property p_old_card_wr;
        @(posedge clk) disable iff (reset) card_wr |-> $past(card_newest);
    endproperty
    a_old_card_wr: assert property (p_old_card_wr) else $error("write to old card"); // R6
    property p_clear_invalid;
        @(posedge clk) disable iff (reset)
        state_r == pctc_pkg::PCTC_CLR |=> !int_valid_r ##0 prog_clear;
    endproperty
    a_clear_invalid: assert property (p_clear_invalid) else $error("clear kept valid"); // R14
    property p_cancel;
        @(posedge clk) disable iff (reset)
        state_r == pctc_pkg::PCTC_CONF && cmd_cancel |=> state_r == pctc_pkg::PCTC_IDLE;
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel ignored"); // R11
    property p_busy;
        @(posedge clk) disable iff (reset) state_r == pctc_pkg::PCTC_CONF |-> busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy low while pending"); // R19
    property p_menu;
        @(posedge clk) disable iff (reset) card_menu_en |-> card_present && !card_fault;
    endproperty
    a_menu: assert property (p_menu) else $error("menu without card"); // R10
    property p_buserr;
        @(posedge clk) disable iff (reset)
        state_r == pctc_pkg::PCTC_CWR && !card_ok |=> ev[pctc_pkg::IRQ_BUSERR] && !busy;
    endproperty
    a_buserr: assert property (p_buserr) else $error("bus error not flagged"); // R18
    property p_ack;
        @(posedge clk) disable iff (reset) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held"); // R19
    c_save: cover property (@(posedge clk) card_wr ##1 ev[pctc_pkg::IRQ_DONE]);
    c_load: cover property (@(posedge clk) prog_clear ##[1:50] prog_wr);
    c_ref:  cover property (@(posedge clk) ev[pctc_pkg::IRQ_REFUSED]);
endmodule

/* pctc_card_model.sv */
// partner: removable program card holding one image, with fault knobs
`timescale 1ns/1ns
module pctc_card_model (
    // system
    input  wire logic        clk,
    // access from the controller
    input  wire logic        card_rd,
    input  wire logic        card_wr,
    input  wire logic        card_erase,
    input  wire logic [15:0] card_addr,
    input  wire logic [31:0] card_wdata,
    // fault knobs from the bench
    input  wire logic        rearm,
    input  wire logic [7:0]  bad_at,
    input  wire logic [7:0]  fault_at,
    // card answers
    output logic             card_valid,
    output logic             card_fault,
    output logic      [31:0] card_rdata
);
    logic [31:0] mem [256];
    int          n_rd;
    int          n_wr;

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 32'h5a00_0000 + i;
        n_rd = 0;
        n_wr = 0;
        card_rdata = 32'h0000_0000;
    end
    // one image per card, so erase wipes the whole store
    always @(posedge clk) begin
        if (card_erase) begin
            for (int i = 0; i < 256; i++) mem[i] <= 32'hffff_ffff;
        end else if (card_wr) begin
            mem[card_addr[7:0]] <= card_wdata;
        end
    end
    // data line toggles between the last word and its inverse once the read strobe is gone
    always @(posedge clk) begin
        card_rdata <= card_rd ? mem[card_addr[7:0]] : ~card_rdata;
    end
    always @(posedge clk) begin
        n_rd <= rearm ? 0 : n_rd + int'(card_rd);
        n_wr <= rearm ? 0 : n_wr + int'(card_wr);
    end
    // image turns bad or card fails after a set number of words
    assign card_valid = !(bad_at != 8'h00 && n_rd >= int'(bad_at));
    assign card_fault = fault_at != 8'h00 && n_wr >= int'(fault_at);
endmodule

/* pctc_top_tb.sv */
// testbench: program card transfer controller
`timescale 1ns/1ns
module pctc_top_tb;
    localparam int BW  = 4;
    localparam int NB  = 2;
    localparam int TOT = BW * NB;
    logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, busy, card_menu_en;
    logic        cmd_save, cmd_load, cmd_erase, cmd_ok, cmd_cancel, menu_program, status_display;
    logic        card_present, card_newest, card_fault, card_valid, card_rd, card_wr;
    logic        card_erase, prog_rd, prog_wr, prog_clear, rearm;
    logic [7:0]  wb_adr_i, bad_at, fault_at;
    logic [15:0] card_addr, prog_addr;
    logic [31:0] wb_dat_i, wb_dat_o, card_rdata, card_wdata, prog_rdata, prog_wdata, rd_q;
    int          err_total, n_compared, cyc_n;
    int          cnt [6];
    int          base [6];
    logic [5:0]  ev;

    pctc_top #(.BLK_WORDS(BW), .N_BLKS(NB)) i_pctc_top (
        .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .cmd_save(cmd_save),
        .cmd_load(cmd_load), .cmd_erase(cmd_erase), .cmd_ok(cmd_ok), .cmd_cancel(cmd_cancel),
        .menu_program(menu_program), .status_display(status_display), .busy(busy),
        .card_menu_en(card_menu_en), .card_present(card_present), .card_newest(card_newest),
        .card_fault(card_fault), .card_valid(card_valid), .card_rdata(card_rdata),
        .card_rd(card_rd), .card_wr(card_wr), .card_erase(card_erase),
        .card_addr(card_addr), .card_wdata(card_wdata), .prog_present(1'b1),
        .prog_rdata(prog_rdata), .prog_rd(prog_rd), .prog_wr(prog_wr),
        .prog_clear(prog_clear), .prog_addr(prog_addr), .prog_wdata(prog_wdata));
    pctc_card_model i_pctc_card_model (
        .clk(clk), .card_rd(card_rd), .card_wr(card_wr), .card_erase(card_erase),
        .card_addr(card_addr), .card_wdata(card_wdata), .rearm(rearm), .bad_at(bad_at),
        .fault_at(fault_at), .card_valid(card_valid), .card_fault(card_fault),
        .card_rdata(card_rdata));

    always #10 clk = ~clk;
    assign ev = {prog_clear, prog_rd, prog_wr, card_erase, card_wr, card_rd};
    always @(posedge clk) begin
        prog_rdata <= {16'h0c3c, prog_addr};
        cyc_n <= cyc_n + 1;
        for (int i = 0; i < 6; i++) cnt[i] <= cnt[i] + int'(ev[i]);
        if (prog_wr) chk("ld data", i_pctc_card_model.mem[prog_addr[7:0]], prog_wdata);
        if (cyc_n == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // classic single cycle; ack and read data taken at the same edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        rd_q = wb_dat_o;
        if (n >= 100) chk("wb ack", 1, 0);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        #1;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd_q);
    endtask
    // operator keys are one-cycle pulses, spaced apart
    task automatic cmd(input int k);
        @(posedge clk);
        case (k)
            0: cmd_save <= 1'b1;
            1: cmd_load <= 1'b1;
            2: cmd_erase <= 1'b1;
            3: cmd_ok <= 1'b1;
            default: cmd_cancel <= 1'b1;
        endcase
        @(posedge clk);
        {cmd_save, cmd_load, cmd_erase, cmd_ok, cmd_cancel} <= 5'h00;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) chk("busy idle", 0, 1);
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [31:0] d(input int i);
        return 32'(cnt[i] - base[i]);
    endfunction
    task automatic op(input int k, input logic [31:0] exp);
        base = cnt;
        cmd(k);
        cmd(3);
        wait_idle();
        rchk("irq status", pctc_pkg::REG_IRQ_ST, exp);
        wb(1'b1, pctc_pkg::REG_IRQ_ST, 32'h0000_000f);
    endtask
    task automatic knobs(input logic [7:0] b, input logic [7:0] f);
        @(posedge clk);
        bad_at <= b;
        fault_at <= f;
        rearm <= 1'b1;
        @(posedge clk);
        rearm <= 1'b0;
    endtask
    task automatic menu(input logic m, input logic s);
        @(posedge clk);
        menu_program <= m;
        status_display <= s;
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial begin
        {clk, wb_cyc_i, wb_stb_i, wb_we_i, rearm, menu_program, status_display} = 7'h00;
        {cmd_save, cmd_load, cmd_erase, cmd_ok, cmd_cancel} = 5'h00;
        {reset, card_present, card_newest} = 3'h7;
        {wb_adr_i, bad_at, fault_at, wb_dat_i, prog_rdata} = '0;
        {err_total, n_compared, cyc_n} = '0;
        for (int i = 0; i < 6; i++) cnt[i] = 0;
        base = cnt;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        wait_idle();
        chk("boot card_rd", TOT, d(0));
        chk("boot prog_wr", TOT, d(3));
        chk("boot clear", 1, d(5));
        rchk("ctrl reset", pctc_pkg::REG_CTRL, pctc_pkg::CTRL_RST);
        rchk("unmapped", 8'h40, 32'h0000_0000);
        rchk("boot irq", pctc_pkg::REG_IRQ_ST, 32'h0000_0001);
        chk("irq masked", 0, irq);
        wb(1'b1, pctc_pkg::REG_IRQ_MK, 32'h0000_000f);
        chk("irq unmasked", 1, irq);
        wb(1'b1, pctc_pkg::REG_IRQ_ST, 32'h0000_0001);
        chk("irq cleared", 0, irq);
        chk("menu before entry", 0, card_menu_en);
        op(0, 32'h0000_0002);
        menu(1'b1, 1'b0);
        chk("menu after entry", 1, card_menu_en);
        menu(1'b0, 1'b0);
        chk("menu kept outside", 1, card_menu_en);
        menu(1'b0, 1'b1);
        chk("menu in status", 0, card_menu_en);
        menu(1'b1, 1'b0);
        // run mode refuses every transfer kind
        wb(1'b1, pctc_pkg::REG_CTRL, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            op(k, 32'h0000_0002);
            chk("run no card access", 0, d(0) + d(1) + d(2) + d(5));
        end
        wb(1'b1, pctc_pkg::REG_CTRL, 32'h0000_0002);
        op(0, 32'h0000_0001);
        chk("save erase", 1, d(2));
        chk("save card_wr", TOT, d(1));
        chk("save prog_rd", TOT, d(4));
        for (int k = 0; k < 3; k++) begin
            base = cnt;
            cmd(k);
            chk("busy in confirm", 1, busy);
            cmd(4);
            chk("busy after cancel", 0, busy);
            chk("cancel no access", 0, d(0) + d(1) + d(2) + d(5));
        end
        op(2, 32'h0000_0001);
        chk("erase pulse", 1, 32'(d(2) != 0));
        chk("erase no write", 0, d(1));
        op(1, 32'h0000_0001);
        chk("load card_rd", TOT, d(0));
        chk("load prog_wr", TOT, d(3));
        chk("load clear", 1, d(5));
        rchk("status", pctc_pkg::REG_STATUS, 32'h0000_001e);
        // older card: readable source only
        @(posedge clk);
        card_newest <= 1'b0;
        op(0, 32'h0000_0002);
        op(2, 32'h0000_0002);
        chk("old card untouched", 0, d(1) + d(2));
        op(1, 32'h0000_0001);
        @(posedge clk);
        card_newest <= 1'b1;
        knobs(8'h06, 8'h00);
        op(1, 32'h0000_0008);
        chk("bad load clear", 1, d(5));
        wb(1'b0, pctc_pkg::REG_STATUS, 32'h0000_0000);
        chk("internal valid", 0, rd_q[pctc_pkg::ST_INT_VALID]);
        knobs(8'h00, 8'h03);
        op(0, 32'h0000_0004);
        // operator repeats the cut save once the card is sound again
        knobs(8'h00, 8'h00);
        op(0, 32'h0000_0001);
        // second power-up with a bad image keeps the stored program
        knobs(8'h01, 8'h00);
        base = cnt;
        @(posedge clk);
        reset <= 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        wait_idle();
        chk("bad boot clear", 0, d(5));
        chk("bad boot prog_wr", 0, d(3));
        rchk("bad boot irq", pctc_pkg::REG_IRQ_ST, 32'h0000_0008);
        wrap_up();
    end
endmodule
